// File: hw/dae_exec.sv
// How it works
// - prefix plus wide group funct 101: 16-bit signed immediate added to ry
// - every sum wraps modulo two to the 64th, never any overflow trap
// - group 01000 bit4 set: signed 4-bit immediate plus rx into ry
// - prefixed 01000 form: 15-bit signed immediate plus rx into ry
// - plain pc form: immediate times four, zero-extended, added to own address
// - in a delay slot the captured jump address is the base of the plain pc form
// - plain pc form result has its two low bits cleared
// - prefixed pc form: address low bits cleared, 16-bit signed immediate added
// - funct 011: signed 8-bit immediate times eight added to register 29
// - prefixed funct 011: unshifted signed 16-bit immediate added to register 29
`timescale 1ns/1ps
module dae_exec (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic DWORD_ENABLE,
	input wire logic INSTR_VALID,
	input wire logic [dae_pkg::DAE_IW-1:0] INSTR,
	input wire logic [dae_pkg::DAE_XLEN-1:0] INSTR_PC,
	input wire logic IS_JUMP,
	input wire logic IN_BRANCH_SHADOW,
	input wire logic RF_WE,
	input wire logic [dae_pkg::DAE_RIDX_W-1:0] RF_WADDR,
	input wire logic [dae_pkg::DAE_XLEN-1:0] RF_WDATA,
	output logic READY,
	output logic WB_VALID,
	output logic [dae_pkg::DAE_RIDX_W-1:0] WB_INDEX,
	output logic [dae_pkg::DAE_XLEN-1:0] WB_DATA,
	output logic RESERVED_EXC
);
	import dae_pkg::*;

	typedef struct packed {
		dae_phase_t phase;
		logic [15:0] ext;
		logic ext_ok;
		logic [63:0] ext_pc;
		logic [63:0] jump_pc;
		logic [63:0] base;
		logic use_reg;
		logic [63:0] imm;
		logic [4:0] dest;
		logic ready;
		logic wb_valid;
		logic [4:0] wb_index;
		logic [63:0] wb_data;
		logic res_exc;
	} dae_state_t;

	dae_state_t st_reg;
	dae_state_t st_next;
	logic [4:0] rd_addr;
	logic [63:0] rd_data;
	logic [63:0] sum;
	logic mem_we;
	logic [4:0] mem_waddr;
	logic [63:0] mem_wdata;

	function automatic logic [4:0] dae_xlat(input logic [2:0] f);
		logic [4:0] r;
		r = {2'h0, f};
		if (f == 3'h0) begin
			r = DAE_XLAT_LOW0;
		end else if (f == 3'h1) begin
			r = DAE_XLAT_LOW1;
		end
		return r;
	endfunction : dae_xlat

	function automatic logic [63:0] dae_sext16(input logic [15:0] v);
		return {{48{v[15]}}, v};
	endfunction : dae_sext16

	always_comb begin
		logic [4:0] major;
		logic [2:0] funct;
		logic [15:0] imm16;
		logic [14:0] imm15;
		logic [63:0] pc_base;
		logic hit;
		logic [63:0] op_imm;
		logic [63:0] op_base;
		logic op_use_reg;
		logic [4:0] op_dest;
		logic [4:0] op_src;
		major = INSTR[DAE_MAJOR_HI:DAE_MAJOR_LO];
		funct = INSTR[DAE_FUNCT_HI:DAE_FUNCT_LO];
		imm16 = {st_reg.ext[4:0], st_reg.ext[10:5], INSTR[4:0]};
		imm15 = {st_reg.ext[3:0], st_reg.ext[10:4], INSTR[3:0]};
		pc_base = st_reg.ext_ok ? st_reg.ext_pc : INSTR_PC;
		hit = 1'b0;
		op_imm = DAE_WORD_RST;
		op_base = DAE_WORD_RST;
		op_use_reg = 1'b0;
		op_dest = dae_xlat(INSTR[DAE_RY_HI:DAE_RY_LO]);
		op_src = op_dest;
		st_next = st_reg;
		st_next.wb_valid = 1'b0;
		st_next.res_exc = 1'b0;
		mem_we = RF_WE;
		mem_waddr = RF_WADDR;
		mem_wdata = RF_WDATA;
		sum = st_reg.base + st_reg.imm;
		if (major == DAE_WIDE_MAJOR_GROUP && funct == DAE_TWO_OPERAND_FUNCT) begin
			hit = 1'b1;
			op_use_reg = 1'b1;
			op_imm = st_reg.ext_ok ? dae_sext16(imm16) : {{59{INSTR[4]}}, INSTR[4:0]};
		end else if (major == DAE_WIDE_MAJOR_GROUP && funct == DAE_PC_REL_FUNCT) begin
			hit = 1'b1;
			if (st_reg.ext_ok) begin
				op_base = pc_base & DAE_LOW2_MASK;
				op_imm = dae_sext16(imm16);
			end else begin
				op_base = (IN_BRANCH_SHADOW ? st_reg.jump_pc : INSTR_PC);
				op_base = op_base & DAE_LOW2_MASK;
				op_imm = {57'h0, INSTR[4:0], 2'h0};
			end
		end else if (major == DAE_WIDE_MAJOR_GROUP && funct == DAE_STACK_ADJUST_FUNCT) begin
			hit = 1'b1;
			op_use_reg = 1'b1;
			op_dest = DAE_SP_INDEX;
			op_src = DAE_SP_INDEX;
			if (st_reg.ext_ok) begin
				op_imm = dae_sext16(imm16);
			end else begin
				op_imm = {{53{INSTR[7]}}, INSTR[7:0], 3'h0};
			end
		end else if (major == DAE_REG_PAIR_IMM_ADD_GROUP && INSTR[DAE_RRI_SEL_BIT]) begin
			hit = 1'b1;
			op_use_reg = 1'b1;
			op_src = dae_xlat(INSTR[DAE_RX_HI:DAE_RX_LO]);
			if (st_reg.ext_ok) begin
				op_imm = {{49{imm15[14]}}, imm15};
			end else begin
				op_imm = {{60{INSTR[3]}}, INSTR[3:0]};
			end
		end
		rd_addr = op_src;
		case (st_reg.phase)
			DAE_IDLE: begin
				if (INSTR_VALID) begin
					if (IS_JUMP) begin
						st_next.jump_pc = INSTR_PC;
					end
					if (major == DAE_PREFIX_OP && !st_reg.ext_ok) begin
						st_next.ext = INSTR;
						st_next.ext_ok = 1'b1;
						st_next.ext_pc = INSTR_PC;
					end else begin
						st_next.ext_ok = 1'b0;
						if (hit && !DWORD_ENABLE) begin
							st_next.res_exc = 1'b1;
						end else if (hit) begin
							st_next.phase = DAE_EXEC;
							st_next.ready = 1'b0;
							st_next.base = op_base;
							st_next.use_reg = op_use_reg;
							st_next.imm = op_imm;
							st_next.dest = op_dest;
						end
					end
				end
			end
			DAE_EXEC: begin
				sum = (st_reg.use_reg ? rd_data : st_reg.base) + st_reg.imm;
				mem_we = 1'b1;
				mem_waddr = st_reg.dest;
				mem_wdata = sum;
				st_next.wb_valid = 1'b1;
				st_next.wb_index = st_reg.dest;
				st_next.wb_data = sum;
				st_next.phase = DAE_IDLE;
				st_next.ready = 1'b1;
			end
			default: begin
				st_next.phase = DAE_IDLE;
				st_next.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_reg.phase <= DAE_IDLE;
			st_reg.ext <= DAE_EXT_RST;
			st_reg.ext_ok <= 1'b0;
			st_reg.ext_pc <= DAE_WORD_RST;
			st_reg.jump_pc <= DAE_WORD_RST;
			st_reg.base <= DAE_WORD_RST;
			st_reg.use_reg <= 1'b0;
			st_reg.imm <= DAE_WORD_RST;
			st_reg.dest <= 5'h00;
			st_reg.ready <= 1'b1;
			st_reg.wb_valid <= 1'b0;
			st_reg.wb_index <= 5'h00;
			st_reg.wb_data <= DAE_WORD_RST;
			st_reg.res_exc <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	dae_gpr_mem #(
		.WIDTH(DAE_XLEN),
		.DEPTH(DAE_NREGS),
		.AW(DAE_RIDX_W)
	) u_gpr (
		.clk(CLK),
		.nrst(NRST),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(rd_addr),
		.rdata(rd_data)
	);

	assign READY = st_reg.ready;
	assign WB_VALID = st_reg.wb_valid;
	assign WB_INDEX = st_reg.wb_index;
	assign WB_DATA = st_reg.wb_data;
	assign RESERVED_EXC = st_reg.res_exc;
endmodule : dae_exec

// File: hw/dae_pkg.sv
package dae_pkg;
	localparam int DAE_XLEN = 64;
	localparam int DAE_IW = 16;
	localparam int DAE_RIDX_W = 5;
	localparam int DAE_NREGS = 32;
	localparam logic [4:0] DAE_PREFIX_OP = 5'h1E;
	localparam logic [4:0] DAE_WIDE_MAJOR_GROUP = 5'h1F;
	localparam logic [4:0] DAE_REG_PAIR_IMM_ADD_GROUP = 5'h08;
	localparam logic [2:0] DAE_TWO_OPERAND_FUNCT = 3'h5;
	localparam logic [2:0] DAE_PC_REL_FUNCT = 3'h6;
	localparam logic [2:0] DAE_STACK_ADJUST_FUNCT = 3'h3;
	localparam logic [4:0] DAE_SP_INDEX = 5'h1D;
	localparam int DAE_PC_SHIFT = 2;
	localparam int DAE_SP_SHIFT = 3;
	localparam int DAE_MAJOR_HI = 15;
	localparam int DAE_MAJOR_LO = 11;
	localparam int DAE_FUNCT_HI = 10;
	localparam int DAE_FUNCT_LO = 8;
	localparam int DAE_RX_HI = 10;
	localparam int DAE_RX_LO = 8;
	localparam int DAE_RY_HI = 7;
	localparam int DAE_RY_LO = 5;
	localparam int DAE_RRI_SEL_BIT = 4;
	localparam logic [4:0] DAE_XLAT_LOW0 = 5'h10;
	localparam logic [4:0] DAE_XLAT_LOW1 = 5'h11;
	localparam logic [15:0] DAE_EXT_RST = 16'h0000;
	localparam logic [63:0] DAE_WORD_RST = 64'h0000000000000000;
	localparam logic [63:0] DAE_LOW2_MASK = 64'hFFFFFFFFFFFFFFFC;

	typedef enum logic {DAE_IDLE, DAE_EXEC} dae_phase_t;
endpackage : dae_pkg

// File: hw/dae_gpr_mem.sv
`timescale 1ns/1ps
module dae_gpr_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read, index zero reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (raddr == '0) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : dae_gpr_mem

// File: verif/dae_chk.sv
`timescale 1ns/1ps
module dae_chk (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic DWORD_ENABLE,
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR,
	input wire logic [63:0] INSTR_PC,
	input wire logic READY,
	input wire logic WB_VALID,
	input wire logic [4:0] WB_INDEX,
	input wire logic [63:0] WB_DATA,
	input wire logic RESERVED_EXC
);
	import dae_pkg::*;
	logic tk, pf, pc, sp, rr, ad, pfx_reg;
	logic [10:0] pw_reg;
	logic [63:0] pp_reg, e8;
	logic [15:0] i16;
	logic [4:0] ry_x;
	assign tk = INSTR_VALID && READY;
	assign pf = INSTR[15:11] == DAE_PREFIX_OP;
	assign pc = INSTR[15:8] == 8'hFE;
	assign sp = INSTR[15:8] == 8'hFB;
	assign rr = INSTR[15:11] == 5'h08 && INSTR[4];
	assign ad = pc || sp || rr || INSTR[15:8] == 8'hFD;
	assign ry_x = INSTR[7:6] == 2'h0 ? {4'h8, INSTR[5]} : {2'h0, INSTR[7:5]};
	assign i16 = {pw_reg[4:0], pw_reg[10:5], INSTR[4:0]};
	assign e8 = {pp_reg[63:2], 2'h0} + {{48{i16[15]}}, i16};
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pfx_reg <= 1'b0;
			pw_reg <= 11'h000;
			pp_reg <= 64'h0;
		end else if (tk) begin
			pfx_reg <= pf && !pfx_reg;
			pw_reg <= INSTR[10:0];
			pp_reg <= INSTR_PC;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_exec;
		!READY ##1 WB_VALID;
	endsequence
	a_add_resp_lat: assert property (tk && DWORD_ENABLE && ad |=> s_exec)
		else $error("add not answered");
	a_sp_dest_fixed: assert property (tk && DWORD_ENABLE && sp |=> ##1 WB_INDEX == 5'h1D)
		else $error("sp index wrong");
	a_dest_xlat: assert property (tk && DWORD_ENABLE && (pc || rr) |=> ##1 WB_INDEX == $past(ry_x, 2))
		else $error("index wrong");
	a_pcrel_align: assert property (tk && DWORD_ENABLE && pc && !pfx_reg |=> ##1 WB_DATA[1:0] == 2'h0)
		else $error("low bits set");
	a_ext_pc_sum: assert property (tk && DWORD_ENABLE && pc && pfx_reg |=> ##1 WB_DATA == $past(e8, 2))
		else $error("pc sum wrong");
	a_rsv_raised: assert property (tk && !DWORD_ENABLE && ad |=> RESERVED_EXC && READY ##1 !WB_VALID)
		else $error("no exception");
	a_rsv_no_write: assert property (RESERVED_EXC |-> !WB_VALID)
		else $error("write on exception");
	a_pfx_silent: assert property (tk && pf && !pfx_reg |=> READY && !WB_VALID ##1 !WB_VALID)
		else $error("prefix answered");
endmodule : dae_chk
bind dae_exec dae_chk u_chk (
	.CLK(CLK),
	.NRST(NRST),
	.DWORD_ENABLE(DWORD_ENABLE),
	.INSTR_VALID(INSTR_VALID),
	.INSTR(INSTR),
	.INSTR_PC(INSTR_PC),
	.READY(READY),
	.WB_VALID(WB_VALID),
	.WB_INDEX(WB_INDEX),
	.WB_DATA(WB_DATA),
	.RESERVED_EXC(RESERVED_EXC)
);

// File: verif/dae_fetch_model.sv
`timescale 1ns/1ps
module dae_fetch_model (
	input wire logic CLK,
	input wire logic READY,
	output logic INSTR_VALID,
	output logic [15:0] INSTR,
	output logic [63:0] INSTR_PC,
	output logic IS_JUMP,
	output logic IN_BRANCH_SHADOW,
	output logic RF_WE,
	output logic [4:0] RF_WADDR,
	output logic [63:0] RF_WDATA
);
	logic last_pf = 1'b0;
	initial begin
		INSTR = 16'h0000;
		INSTR_PC = 64'h0000000000000000;
		idle();
		RF_WE = 1'b0;
		RF_WADDR = 5'h00;
		RF_WDATA = 64'h0;
	end
	task idle;
		INSTR_VALID = 1'b0;
		INSTR = ~INSTR;
		INSTR_PC = ~INSTR_PC;
		IS_JUMP = 1'b0;
		IN_BRANCH_SHADOW = 1'b0;
	endtask : idle
	task send(input logic [15:0] w, input logic [63:0] pc, input logic j, input logic s);
		@(negedge CLK);
		while (!READY) @(negedge CLK);
		INSTR_VALID = 1'b1;
		INSTR = w;
		INSTR_PC = pc;
		IS_JUMP = j;
		IN_BRANCH_SHADOW = s && !last_pf;
		last_pf = w[15:11] == 5'h1E;
		@(posedge CLK);
	endtask : send
	task load(input logic [4:0] a, input logic [63:0] d);
		@(negedge CLK);
		RF_WE = 1'b1;
		RF_WADDR = a;
		RF_WDATA = d;
		@(negedge CLK);
		RF_WE = 1'b0;
		RF_WDATA = ~d;
	endtask : load
endmodule : dae_fetch_model

// File: verif/dae_exec_tb_top.sv
`timescale 1ns/1ps
module dae_exec_tb_top;
	import dae_pkg::*;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic DWORD_ENABLE = 1'b1;
	logic INSTR_VALID, IS_JUMP, IN_BRANCH_SHADOW, RF_WE, READY, WB_VALID, RESERVED_EXC;
	logic [15:0] INSTR;
	logic [4:0] RF_WADDR, WB_INDEX;
	logic [63:0] INSTR_PC, RF_WDATA, WB_DATA;
	int miscompares = 0;
	int comparisons = 0;
	always #5 CLK = ~CLK;
	dae_exec i_dut (
		.CLK(CLK),
		.NRST(NRST),
		.DWORD_ENABLE(DWORD_ENABLE),
		.INSTR_VALID(INSTR_VALID),
		.INSTR(INSTR),
		.INSTR_PC(INSTR_PC),
		.IS_JUMP(IS_JUMP),
		.IN_BRANCH_SHADOW(IN_BRANCH_SHADOW),
		.RF_WE(RF_WE),
		.RF_WADDR(RF_WADDR),
		.RF_WDATA(RF_WDATA),
		.READY(READY),
		.WB_VALID(WB_VALID),
		.WB_INDEX(WB_INDEX),
		.WB_DATA(WB_DATA),
		.RESERVED_EXC(RESERVED_EXC)
	);
	dae_fetch_model i_fm (
		.CLK(CLK),
		.READY(READY),
		.INSTR_VALID(INSTR_VALID),
		.INSTR(INSTR),
		.INSTR_PC(INSTR_PC),
		.IS_JUMP(IS_JUMP),
		.IN_BRANCH_SHADOW(IN_BRANCH_SHADOW),
		.RF_WE(RF_WE),
		.RF_WADDR(RF_WADDR),
		.RF_WDATA(RF_WDATA)
	);
	function automatic logic [15:0] pf(input logic [15:0] m);
		return {5'h1E, m[10:5], m[15:11]};
	endfunction : pf
	task ck(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : ck
	task wb(input logic [4:0] i, input logic [63:0] d);
		@(negedge CLK);
		i_fm.idle();
		ck(READY === 1'b0, "ready");
		@(negedge CLK);
		ck(WB_VALID === 1'b1 && WB_INDEX === i && WB_DATA === d && !RESERVED_EXC, "wb");
	endtask : wb
	task t_two;
		i_fm.load(5'h11, 64'h7FFFFFFFFFFFFFFF);
		i_fm.send(pf(16'h0001), 64'h10, 1'b0, 1'b0);
		i_fm.send(16'hFD21, 64'h12, 1'b0, 1'b0);
		wb(5'h11, 64'h8000000000000000);
	endtask : t_two
	task t_rri;
		i_fm.load(5'h02, 64'h5);
		i_fm.send(16'h421A, 64'h20, 1'b0, 1'b0);
		wb(5'h10, 64'hFFFFFFFFFFFFFFFF);
		i_fm.send(16'hF008, 64'h22, 1'b0, 1'b0);
		i_fm.send(16'h4250, 64'h24, 1'b0, 1'b0);
		wb(5'h02, 64'hFFFFFFFFFFFFC005);
	endtask : t_rri
	task t_pc;
		i_fm.send(16'h0000, 64'h1002, 1'b1, 1'b0);
		i_fm.send(16'hFEFF, 64'h1006, 1'b0, 1'b1);
		wb(5'h07, 64'h107C);
		i_fm.send(16'hFEFF, 64'h2003, 1'b0, 1'b0);
		wb(5'h07, 64'h207C);
		i_fm.send(pf(16'hFFF0), 64'h3006, 1'b0, 1'b0);
		i_fm.send(16'hFE70, 64'h3008, 1'b0, 1'b0);
		wb(5'h03, 64'h2FF4);
	endtask : t_pc
	task t_sp;
		i_fm.load(5'h1D, 64'h100);
		i_fm.send(16'hFBFF, 64'h40, 1'b0, 1'b0);
		wb(5'h1D, 64'hF8);
		i_fm.send(pf(16'h8000), 64'h42, 1'b0, 1'b0);
		i_fm.send(16'hFB00, 64'h44, 1'b0, 1'b0);
		wb(5'h1D, 64'hFFFFFFFFFFFF80F8);
	endtask : t_sp
	task t_rsv;
		DWORD_ENABLE = 1'b0;
		i_fm.send(16'hFB01, 64'h50, 1'b0, 1'b0);
		@(negedge CLK);
		i_fm.idle();
		ck(RESERVED_EXC === 1'b1 && WB_VALID === 1'b0, "exc");
		@(negedge CLK);
		ck(WB_VALID === 1'b0 && READY === 1'b1, "exc wb");
		DWORD_ENABLE = 1'b1;
		i_fm.send(16'hFB00, 64'h52, 1'b0, 1'b0);
		wb(5'h1D, 64'hFFFFFFFFFFFF80F8);
	endtask : t_rsv
	task t_rst;
		i_fm.send(pf(16'h8000), 64'h60, 1'b0, 1'b0);
		@(negedge CLK);
		NRST = 1'b0;
		i_fm.idle();
		@(negedge CLK);
		ck(READY === 1'b1 && WB_VALID === 1'b0 && WB_INDEX === 5'h00, "rst out");
		ck(WB_DATA === 64'h0000000000000000 && RESERVED_EXC === 1'b0, "rst data");
		NRST = 1'b1;
		i_fm.send(16'hFB01, 64'h62, 1'b0, 1'b0);
		wb(5'h1D, 64'hFFFFFFFFFFFF8100);
	endtask : t_rst
	task end_sim;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (10) @(negedge CLK);
		NRST = 1'b1;
		t_two();
		t_rri();
		t_pc();
		t_sp();
		t_rsv();
		t_rst();
		end_sim();
	end
	initial begin
		#5000;
		miscompares++;
		end_sim();
	end
endmodule : dae_exec_tb_top
